// ### hdl/fpes_pkg.sv
package fpes_pkg;
	// Command opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h33;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_CE1 = 8'hC7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESM = 8'h7A;
	// Bit counts at frame boundaries
	localparam logic [15:0] NB_OPC = 16'h0008;
	localparam logic [15:0] NB_SRW = 16'h0010;
	localparam logic [15:0] NB_ADR = 16'h0020;
	localparam logic [15:0] NB_DAT1 = 16'h0028;
	localparam logic [15:0] NB_MAX = 16'hFFFF;
	localparam logic [15:0] W_ONE = 16'h0001;
	localparam logic [15:0] W_QUAD = 16'h0004;
	// Timing
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned RESUME_NS = 200;
	localparam logic [31:0] RESUME_CYC = 32'(RESUME_NS * CLK_MHZ / 1000);
	// Operation kinds
	localparam logic [2:0] K_PROG = 3'h0;
	localparam logic [2:0] K_4K = 3'h1;
	localparam logic [2:0] K_32K = 3'h2;
	localparam logic [2:0] K_64K = 3'h3;
	localparam logic [2:0] K_ALL = 3'h4;
	localparam logic [23:0] M_PAGE = 24'h0000FF;
	localparam logic [23:0] M_4K = 24'h000FFF;
	localparam logic [23:0] M_32K = 24'h007FFF;
	localparam logic [23:0] M_64K = 24'h00FFFF;
	// Protection geometry
	localparam logic [4:0] PROT_SEC_SH = 5'h0C;
	localparam logic [4:0] PROT_BLK_SH = 5'h10;
	localparam logic [24:0] ARRAY_LIM = 25'h1000000;
	// Pin vector layout and its reset value (chip select idle high)
	localparam int IX_CS = 5;
	localparam int IX_SCK = 4;
	localparam int IX_SO = 1;
	localparam logic [5:0] PIN_RST = 6'h20;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_RUN = 5'b00010,
		S_SUSP = 5'b00100,
		S_PAUSED = 5'b01000,
		S_RESM = 5'b10000
	} fpes_seq_e;
endpackage : fpes_pkg

// ### hdl/fpes_fifo.sv
`timescale 1ns/10ps
module fpes_fifo
	import fpes_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
)(
	input wire logic clock, // System clock
	input wire logic rst, // Async reset, high
	input wire logic ce, // Clock enable
	input wire logic in_valid, // Write request
	output logic in_ready, // Space available
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Output word held
	input wire logic out_ready, // Sink takes word
	output logic [WIDTH-1:0] out_data // Output word
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ov_q, ov_d;
	logic [WIDTH-1:0] od_q, od_d;
	logic push, load;

	always_comb
	begin
		in_ready = cnt_q != FULL;
		push = in_valid && in_ready;
		load = (cnt_q != '0) && (!ov_q || out_ready);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = load ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
		ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
		od_d = load ? mem_q[rd_q] : od_q;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else if (ce)
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge clock)
	begin
		if (ce && push)
			mem_q[wr_q] <= in_data;
	end

	assign out_valid = ov_q;
	assign out_data = od_q;
endmodule : fpes_fifo

// ### hdl/fpes_ctrl.sv
`timescale 1ns/10ps
module fpes_ctrl
	import fpes_pkg::*;
#(
	parameter int unsigned WRITE_PAGE_US = 700,
	parameter int unsigned WIPE_4K_US = 45000,
	parameter int unsigned WIPE_32K_US = 120000,
	parameter int unsigned WIPE_64K_US = 150000,
	parameter int unsigned WIPE_ALL_US = 20000000,
	parameter int unsigned PAUSE_US = 20,
	parameter int FIFO_DEPTH = 32
)(
	input wire logic clock, // 40 MHz system clock
	input wire logic rst, // Async reset, high
	input wire logic ce, // Clock enable
	input wire logic cs_n, // Chip select pin
	input wire logic sclk, // Serial clock pin
	input wire logic [3:0] io_in, // IO pins in
	output logic [3:0] io_out, // IO pins out
	output logic [3:0] io_oe, // IO drive enables
	input wire logic four_line_permit, // Quad transfers allowed
	input wire logic protect_invert, // Invert protected range
	input wire logic small_unit_protect, // 4K protect units
	input wire logic protect_from_low_end, // Range from address 0
	input wire logic protect_range_bit2, // Range size bit 2
	input wire logic protect_range_bit1, // Range size bit 1
	input wire logic protect_range_bit0, // Range size bit 0
	output logic busy, // Operation in progress
	output logic write_latch_flag, // Write enabled
	output logic paused_op_flag, // Operation suspended
	output logic op_start, // Start pulse to array
	output logic [2:0] op_kind, // Kind of operation
	output logic [23:0] op_addr, // Base address
	output logic op_pause, // Array must hold still
	output logic status_wr_strobe, // Status write accepted
	output logic mem_page_clear, // Clear page latch
	output logic mem_wr_valid, // Page latch byte valid
	output logic [7:0] mem_wr_col, // Byte offset in page
	output logic [7:0] mem_wr_data, // Byte value
	input wire logic mem_wr_ready // Page latch takes byte
);
	localparam logic [31:0] WPG_CYC = 32'(WRITE_PAGE_US * CLK_MHZ);
	localparam logic [31:0] W4K_CYC = 32'(WIPE_4K_US * CLK_MHZ);
	localparam logic [31:0] W32K_CYC = 32'(WIPE_32K_US * CLK_MHZ);
	localparam logic [31:0] W64K_CYC = 32'(WIPE_64K_US * CLK_MHZ);
	localparam logic [31:0] WALL_CYC = 32'(WIPE_ALL_US * CLK_MHZ);
	localparam logic [31:0] PAUSE_CYC = 32'(PAUSE_US * CLK_MHZ);

	function automatic logic is_prog(input logic [7:0] op);
		return op == OP_PP || op == OP_QPP;
	endfunction : is_prog

	function automatic logic [2:0] kind_of(input logic [7:0] op);
		unique case (op)
			OP_SE: return K_4K;
			OP_BE32: return K_32K;
			OP_BE64: return K_64K;
			OP_CE1, OP_CE2: return K_ALL;
			default: return K_PROG;
		endcase
	endfunction : kind_of

	function automatic logic [23:0] span(input logic [2:0] k);
		unique case (k)
			K_4K: return M_4K;
			K_32K: return M_32K;
			K_64K: return M_64K;
			K_ALL: return '1; // Whole array reports base zero
			default: return M_PAGE;
		endcase
	endfunction : span

	function automatic logic [31:0] dur(input logic [2:0] k);
		unique case (k)
			K_4K: return W4K_CYC;
			K_32K: return W32K_CYC;
			K_64K: return W64K_CYC;
			K_ALL: return WALL_CYC;
			default: return WPG_CYC;
		endcase
	endfunction : dur

	function automatic logic prot_at(input logic [23:0] a, input logic [2:0] bp, input logic tb,
		input logic sec, input logic cmp);
		logic [4:0] sh;
		logic [24:0] lim;
		logic hit;
		sh = (sec ? PROT_SEC_SH : PROT_BLK_SH) + {2'h0, bp} - 5'h01;
		lim = 25'h0000001 << sh;
		hit = tb ? ({1'b0, a} < lim) : ({1'b0, a} >= ARRAY_LIM - lim);
		return ((bp != 3'h0) && hit) ^ cmp;
	endfunction : prot_at

	// Pin synchronisers: three stages, value taken when stages two and three agree
	logic [5:0] sy1_q, sy2_q, sy3_q, pin_q, pin_d, prv_q;
	logic cs_lo, sck_rise, sck_fall, fr_end;

	always_comb
	begin
		for (int i = 0; i < 6; i++)
			pin_d[i] = (sy2_q[i] == sy3_q[i]) ? sy3_q[i] : pin_q[i];
		cs_lo = !pin_q[IX_CS];
		sck_rise = pin_q[IX_SCK] && !prv_q[IX_SCK];
		sck_fall = !pin_q[IX_SCK] && prv_q[IX_SCK];
		fr_end = pin_q[IX_CS] && !prv_q[IX_CS];
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sy1_q <= PIN_RST;
			sy2_q <= PIN_RST;
			sy3_q <= PIN_RST;
			pin_q <= PIN_RST;
			prv_q <= PIN_RST;
		end
		else if (ce)
		begin
			sy1_q <= {cs_n, sclk, io_in};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			pin_q <= pin_d;
			prv_q <= pin_q;
		end
	end

	// Frame receiver
	logic [7:0] opc_q, opc_d, dat_q, dat_d, col_q, col_d, sho_q, sho_d, stat1, stat2;
	logic [15:0] nb_q, nb_d, w, nb_n;
	logic [23:0] adr_q, adr_d;
	logic ovr_q, ovr_d, clr_q, clr_d;
	logic [3:0] iout_q, iout_d, ioe_q, ioe_d;
	logic push, push_rdy, pg_ok, busy_q, wel_q, paused_q;
	logic [2:0] bp;

	assign bp = {protect_range_bit2, protect_range_bit1, protect_range_bit0};

	always_comb
	begin
		opc_d = opc_q;
		nb_d = nb_q;
		adr_d = adr_q;
		dat_d = dat_q;
		col_d = col_q;
		sho_d = sho_q;
		ovr_d = ovr_q;
		iout_d = iout_q;
		ioe_d = ioe_q;
		clr_d = 1'b0;
		push = 1'b0;
		stat1 = {1'b0, small_unit_protect, protect_from_low_end, bp, wel_q, busy_q};
		stat2 = {paused_op_flag, protect_invert, 4'h0, four_line_permit, 1'b0};
		w = (opc_q == OP_QPP && nb_q >= NB_OPC) ? W_QUAD : W_ONE;
		nb_n = (nb_q > NB_MAX - w) ? NB_MAX : nb_q + w;
		pg_ok = is_prog(opc_q) && !busy_q && !paused_q;
		if (fr_end)
		begin
			nb_d = '0;
			ovr_d = 1'b0;
			ioe_d = '0;
			iout_d = '0;
		end
		else if (cs_lo && sck_rise)
		begin
			nb_d = nb_n;
			if (nb_q < NB_OPC)
			begin
				opc_d = {opc_q[6:0], pin_q[0]};
				sho_d = (opc_d == OP_RDSR2) ? stat2 : stat1;
				clr_d = (nb_n == NB_OPC) && is_prog(opc_d) && !busy_q && !paused_q;
			end
			else if (nb_q < NB_ADR)
			begin
				adr_d = (w == W_QUAD) ? {adr_q[19:0], pin_q[3:0]} : {adr_q[22:0], pin_q[0]};
				if (nb_n == NB_ADR)
					col_d = adr_d[7:0];
			end
			else
			begin
				dat_d = (w == W_QUAD) ? {dat_q[3:0], pin_q[3:0]} : {dat_q[6:0], pin_q[0]};
				if (nb_n[2:0] == 3'h0 && pg_ok)
				begin
					if (push_rdy)
					begin
						push = 1'b1;
						col_d = col_q + 8'h01;
					end
					else
						ovr_d = 1'b1;
				end
			end
		end
		else if (cs_lo && sck_fall && nb_q >= NB_OPC && (opc_q == OP_RDSR1 || opc_q == OP_RDSR2))
		begin
			iout_d[IX_SO] = sho_q[7];
			ioe_d[IX_SO] = 1'b1;
			sho_d = {sho_q[6:0], sho_q[7]};
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			opc_q <= '0;
			nb_q <= '0;
			adr_q <= '0;
			dat_q <= '0;
			col_q <= '0;
			sho_q <= '0;
			ovr_q <= 1'b0;
			clr_q <= 1'b0;
			iout_q <= '0;
			ioe_q <= '0;
		end
		else if (ce)
		begin
			opc_q <= opc_d;
			nb_q <= nb_d;
			adr_q <= adr_d;
			dat_q <= dat_d;
			col_q <= col_d;
			sho_q <= sho_d;
			ovr_q <= ovr_d;
			clr_q <= clr_d;
			iout_q <= iout_d;
			ioe_q <= ioe_d;
		end
	end

	fpes_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(push),
		.in_ready(push_rdy),
		.in_data({col_q, dat_d}),
		.out_valid(mem_wr_valid),
		.out_ready(mem_wr_ready),
		.out_data({mem_wr_col, mem_wr_data})
	);

	// Command decision at chip select rise, and the operation sequencer
	fpes_seq_e seq_q, seq_d;
	logic [31:0] rem_q, rem_d, lat_q, lat_d;
	logic [2:0] kind_q, kind_d, fk;
	logic [23:0] base_q, base_d, fbase;
	logic busy_d, wel_d, paused_d, start_q, start_d, pause_q, pause_d, sw_q, sw_d;
	logic one, er_frame, pg_frame, hit, start_go, sus_go, res_go, sw_go, susp_prog;

	always_comb
	begin
		one = nb_q == NB_OPC;
		fk = kind_of(opc_q);
		fbase = adr_q & ~span(fk);
		er_frame = (((opc_q == OP_SE || opc_q == OP_BE32 || opc_q == OP_BE64) && nb_q == NB_ADR)
			|| ((opc_q == OP_CE1 || opc_q == OP_CE2) && one));
		pg_frame = is_prog(opc_q) && nb_q >= NB_DAT1 && nb_q[2:0] == 3'h0 && !ovr_q
			&& (opc_q != OP_QPP || four_line_permit);
		hit = (fk == K_ALL) ? ((bp != 3'h0) || protect_invert)
			: (prot_at(fbase, bp, protect_from_low_end, small_unit_protect, protect_invert)
			|| prot_at(fbase | span(fk), bp, protect_from_low_end, small_unit_protect, protect_invert));
		start_go = fr_end && seq_q == S_IDLE && wel_q && (er_frame || pg_frame) && !hit;
		sus_go = fr_end && one && opc_q == OP_SUSP && seq_q == S_RUN && kind_q != K_ALL;
		res_go = fr_end && one && opc_q == OP_RESM && seq_q == S_PAUSED;
		sw_go = fr_end && nb_q == NB_SRW && (opc_q == OP_WRSR1 || opc_q == OP_WRSR2)
			&& wel_q && !busy_q && !paused_q;
		susp_prog = paused_q && kind_q == K_PROG;
		seq_d = seq_q;
		rem_d = rem_q;
		lat_d = lat_q;
		kind_d = kind_q;
		base_d = base_q;
		busy_d = busy_q;
		paused_d = paused_q;
		start_d = 1'b0;
		sw_d = sw_go;
		wel_d = wel_q;
		if (fr_end && one && opc_q == OP_WREN && !busy_q)
			wel_d = 1'b1;
		else if ((fr_end && one && opc_q == OP_WRDI && !busy_q) || sw_go)
			wel_d = 1'b0;
		unique case (seq_q)
			S_IDLE:
				if (start_go)
				begin
					seq_d = S_RUN;
					busy_d = 1'b1;
					wel_d = 1'b0;
					kind_d = fk;
					base_d = (fk == K_PROG) ? adr_q : fbase;
					rem_d = dur(fk);
					start_d = 1'b1;
				end
			S_RUN:
				if (sus_go)
				begin
					seq_d = S_SUSP;
					paused_d = 1'b1;
					lat_d = PAUSE_CYC;
				end
				else if (rem_q <= 32'h1)
				begin
					seq_d = S_IDLE;
					busy_d = 1'b0;
				end
				else
					rem_d = rem_q - 32'h1;
			S_SUSP:
				if (lat_q <= 32'h1)
				begin
					seq_d = S_PAUSED;
					busy_d = 1'b0;
				end
				else
					lat_d = lat_q - 32'h1;
			S_PAUSED:
				if (res_go)
				begin
					seq_d = S_RESM;
					paused_d = 1'b0;
					lat_d = RESUME_CYC;
				end
			S_RESM:
				if (lat_q <= 32'h1)
				begin
					seq_d = S_RUN;
					busy_d = 1'b1;
				end
				else
					lat_d = lat_q - 32'h1;
		endcase
		pause_d = seq_d == S_SUSP || seq_d == S_PAUSED || seq_d == S_RESM;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			seq_q <= S_IDLE;
			rem_q <= '0;
			lat_q <= '0;
			kind_q <= K_PROG;
			base_q <= '0;
			busy_q <= 1'b0;
			wel_q <= 1'b0;
			paused_q <= 1'b0;
			start_q <= 1'b0;
			pause_q <= 1'b0;
			sw_q <= 1'b0;
		end
		else if (ce)
		begin
			seq_q <= seq_d;
			rem_q <= rem_d;
			lat_q <= lat_d;
			kind_q <= kind_d;
			base_q <= base_d;
			busy_q <= busy_d;
			wel_q <= wel_d;
			paused_q <= paused_d;
			start_q <= start_d;
			pause_q <= pause_d;
			sw_q <= sw_d;
		end
	end

	assign io_out = iout_q;
	assign io_oe = ioe_q;
	assign busy = busy_q;
	assign write_latch_flag = wel_q;
	assign paused_op_flag = paused_q;
	assign op_start = start_q;
	assign op_kind = kind_q;
	assign op_addr = base_q;
	assign op_pause = pause_q;
	assign status_wr_strobe = sw_q;
	assign mem_page_clear = clr_q;

	localparam int CHK_RES = 8;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence seq_res_taken;
		ce && res_go;
	endsequence
	sequence seq_busy_back;
		!paused_q ##[1:CHK_RES] busy_q;
	endsequence
	chk_wel_start: assert property (ce && start_go |=> !wel_q && busy_q && op_start) else $error("latch not cleared at start");
	chk_pause_set: assert property (ce && sus_go |=> paused_q && busy_q) else $error("pause not immediate");
	chk_resume_bsy: assert property (seq_res_taken |=> seq_busy_back) else $error("busy not back after resume");
	chk_no_arr_sus: assert property (ce && fr_end && seq_q == S_RUN && kind_q == K_ALL |=> !paused_q) else $error("array erase suspended");
	chk_quad_gate: assert property (fr_end && opc_q == OP_QPP && !four_line_permit |=> !op_start) else $error("quad without permit");
	chk_busy_ign: assert property (fr_end && busy_q |=> !op_start) else $error("start while busy");
	chk_bad_edge: assert property (fr_end && er_frame == 1'b0 && !is_prog(opc_q) |=> !op_start) else $error("erase on bad frame");
	chk_pause_rej: assert property (fr_end && (paused_q || susp_prog) |=> !op_start && !status_wr_strobe) else $error("accepted while paused");
	chk_wren_set: assert property (ce && fr_end && one && opc_q == OP_WREN && !busy_q |=> write_latch_flag) else $error("write enable lost");
	chk_prot_skip: assert property (fr_end && hit |=> !op_start) else $error("protected target started");
endmodule : fpes_ctrl

// ### bench/fpes_host_model.sv
`timescale 1ns/10ps
module fpes_host_model (
	input wire logic clock, // System clock
	input wire logic [3:0] so, // IO lines from the device
	input wire logic [3:0] so_oe, // Device drive enables
	output logic cs_n, // Chip select
	output logic sclk, // Serial clock, low between frames
	output logic [3:0] io // IO lines
);
	logic [7:0] rx; // Last eight bits seen on IO1, unknown where undriven
	initial
	begin
		rx = 8'h00;
		cs_n = 1'b1;
		sclk = 1'b0;
		io = 4'hA;
	end
	task automatic half();
		repeat (4) @(posedge clock);
		#1;
	endtask : half
	task automatic pulse();
		half();
		sclk = 1'b1;
		half();
		rx = {rx[6:0], so_oe[1] ? so[1] : 1'bx};
		sclk = 1'b0;
	endtask : pulse
	// Opcode on line 0, then nb payload bits MSB first; quad moves a nibble each clock
	task automatic xfer(input logic [7:0] op, input logic [63:0] pay, input int nb, input bit quad);
		int i;
		half();
		half();
		cs_n = 1'b0;
		for (i = 7; i >= 0; i--)
		begin
			io = {~io[3:1], op[i]};
			pulse();
		end
		i = nb;
		while (i > 0)
		begin
			if (quad)
				io = pay[((i - 1) % 64) -: 4];
			else
				io = {~io[3:1], pay[(i - 1) % 64]};
			i -= quad ? 4 : 1;
			pulse();
		end
		half();
		cs_n = 1'b1;
		io = ~io;
	endtask : xfer
endmodule : fpes_host_model

// ### bench/fpes_ctrl_tb.sv
`timescale 1ns/10ps
module fpes_ctrl_tb
	import fpes_pkg::*;
;
	localparam int C = 40;
	logic clock, mem_wr_ready, busy, wlf, paused, op_start, op_pause, srw, mvalid, cs_n, sclk, pclr;
	logic rst = 1'b1, permit = 1'b0, low_end = 1'b0, skip = 1'b0, ce = 1'b1, inv = 1'b0, sup = 1'b0;
	logic [2:0] bp = 3'h0;
	logic [1:0] rmode = 2'h1;
	logic [3:0] io_in, io_out, io_oe;
	logic [2:0] op_kind;
	logic [23:0] op_addr, a;
	logic [7:0] mcol, mdata;
	logic [31:0] d, rnd = 32'h46D3;
	int fails = 0, compares = 0, cycles = 0, nsrw = 0, nclr = 0, i, k;
	logic [2:0] q_kind[$];
	logic [23:0] q_addr[$];
	int q_dur[$];
	logic [15:0] q_mem[$];
	logic [7:0] e_op[5] = '{OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
	logic [2:0] e_kd[5] = '{K_4K, K_32K, K_64K, K_ALL, K_ALL};
	logic [23:0] e_mk[5] = '{M_4K, M_32K, M_64K, 24'hFFFFFF, 24'hFFFFFF};
	int e_us[5] = '{4, 5, 6, 40, 40};

	fpes_ctrl #(.WRITE_PAGE_US(5), .WIPE_4K_US(4), .WIPE_32K_US(5), .WIPE_64K_US(6), .WIPE_ALL_US(40),
		.PAUSE_US(1), .FIFO_DEPTH(32)) dut (.clock(clock), .rst(rst), .ce(ce), .cs_n(cs_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .four_line_permit(permit), .protect_invert(inv),
		.small_unit_protect(sup), .protect_from_low_end(low_end), .protect_range_bit2(bp[2]),
		.protect_range_bit1(bp[1]), .protect_range_bit0(bp[0]), .busy(busy), .write_latch_flag(wlf),
		.paused_op_flag(paused), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_pause(op_pause),
		.status_wr_strobe(srw), .mem_page_clear(pclr), .mem_wr_valid(mvalid), .mem_wr_col(mcol),
		.mem_wr_data(mdata), .mem_wr_ready(mem_wr_ready));
	fpes_host_model host (.clock(clock), .so(io_out), .so_oe(io_oe), .cs_n(cs_n), .sclk(sclk), .io(io_in));

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic err(input string m);
		fails++;
		$display("Error at %0t: %s", $time, m);
	endtask : err
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp)
			err($sformatf("%s got %0h expected %0h", m, got, exp));
	endtask : chk_val
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// Page latch side stalls at random in mode 2
	always @(posedge clock)
	begin
		#1;
		rnd = lfsr(rnd);
		mem_wr_ready = rmode[1] ? rnd[4] : rmode[0];
		cycles++;
		if (cycles == 60000)
		begin
			err("run took too long");
			final_report();
		end
	end
	initial
	begin : op_mon
		int n, dur;
		forever
		begin
			@(negedge clock);
			if (op_start === 1'b1 && q_kind.size() == 0)
				err("unexpected operation start");
			else if (op_start === 1'b1)
			begin
				dur = q_dur.pop_front();
				chk_val(op_kind, q_kind.pop_front(), "kind");
				chk_val(op_addr, q_addr.pop_front(), "address");
				chk_val({busy, wlf}, 2'b10, "busy and latch at start");
				n = 0;
				while (busy === 1'b1 && n < 3000)
				begin
					@(negedge clock);
					n++;
				end
				if (dur != 0)
					chk_val(32'(n > dur - 4 && n < dur + 4), 1, "busy length");
			end
		end
	end
	always @(negedge clock)
	begin
		if (srw === 1'b1)
			nsrw++;
		if (pclr === 1'b1)
			nclr++;
		if (mvalid === 1'b1 && mem_wr_ready === 1'b1 && !skip && q_mem.size() == 0)
			err("unexpected page byte");
		else if (mvalid === 1'b1 && mem_wr_ready === 1'b1 && !skip)
			chk_val({mcol, mdata}, q_mem.pop_front(), "page byte");
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic cmd(input logic [7:0] op, input logic [63:0] pay, input int nb, input bit q);
		host.xfer(op, pay, nb, q);
		cyc(12);
	endtask : cmd
	task automatic wren();
		cmd(OP_WREN, 64'h0, 0, 1'b0);
		chk_val(wlf, 1'b1, "latch after enable");
	endtask : wren
	task automatic expect_op(input logic [2:0] kd, input logic [23:0] ad, input int dur);
		q_kind.push_back(kd);
		q_addr.push_back(ad);
		q_dur.push_back(dur);
	endtask : expect_op
	// Waits for the operation to end and the page buffer to empty
	task automatic idle();
		int n;
		n = 0;
		while ((busy !== 1'b0 || mvalid !== 1'b0) && n < 3000)
		begin
			cyc(1);
			n++;
		end
		if (n >= 3000)
			err("wait bound reached");
		cyc(4);
	endtask : idle
	task automatic done(input string m);
		cyc(4);
		chk_val(q_kind.size() + q_mem.size(), 0, "results left over");
		$display("Test %s finished", m);
	endtask : done

	initial
	begin
		cyc(2);
		rst = 1'b0;
		cyc(6);
		wren();
		cmd(OP_WRSR1, 64'h0, 8, 1'b0);
		chk_val(nsrw, 1, "status write taken");
		cmd(OP_SE, 64'h0, 24, 1'b0);
		wren();
		cmd(OP_SE, 64'h0, 23, 1'b0);
		wren();
		cmd(OP_BE64, 64'h0, 25, 1'b0);
		for (k = 0; k < 5; k++)
		begin
			a = rnd[23:0];
			wren();
			expect_op(e_kd[k], a & ~e_mk[k], e_us[k] * C + ((k == 0) ? 20 : 0));
			cmd(e_op[k], 64'(a), (k < 3) ? 24 : 0, 1'b0);
			if (k == 0)
			begin
				// Frozen cycles stretch the busy time by as many
				ce = 1'b0;
				cyc(20);
				ce = 1'b1;
			end
			idle();
		end
		done("erase kinds");
		bp = 3'h1;
		wren();
		cmd(OP_SE, 64'hFF0123, 24, 1'b0);
		wren();
		cmd(OP_CE1, 64'h0, 0, 1'b0);
		low_end = 1'b1;
		wren();
		cmd(OP_SE, 64'h001234, 24, 1'b0);
		low_end = 1'b0;
		expect_op(K_4K, 24'h001000, C * 4);
		cmd(OP_SE, 64'h001234, 24, 1'b0);
		idle();
		sup = 1'b1;
		wren();
		expect_op(K_4K, 24'hFFE000, C * 4);
		cmd(OP_SE, 64'hFFE123, 24, 1'b0);
		idle();
		wren();
		cmd(OP_SE, 64'hFFF123, 24, 1'b0);
		sup = 1'b0;
		bp = 3'h0;
		inv = 1'b1;
		cmd(OP_SE, 64'h001234, 24, 1'b0);
		inv = 1'b0;
		done("protection");
		skip = 1'b1;
		wren();
		cmd(OP_QPP, 64'h00000155, 32, 1'b1);
		idle();
		skip = 1'b0;
		permit = 1'b1;
		rmode = 2'h2;
		nclr = 0;
		for (k = 0; k < 2; k++)
		begin
			a = {rnd[23:8], 8'hFE};
			d = rnd;
			wren();
			expect_op(K_PROG, a, C * 5);
			for (i = 0; i < 4; i++)
				q_mem.push_back({8'(8'hFE + i), d[31 - 8 * i -: 8]});
			cmd(k ? OP_QPP : OP_PP, {8'h0, a, d}, 56, 1'(k));
			chk_val(nclr, k + 1, "page clear pulse");
			idle();
		end
		rmode = 2'h0;
		skip = 1'b1;
		wren();
		cmd(OP_PP, 64'h0123456789ABCDEF, 24 + 8 * 48, 1'b0);
		rmode = 2'h2;
		idle();
		skip = 1'b0;
		done("program and buffer");
		for (k = 0; k < 2; k++)
		begin
			cmd(OP_SUSP, 64'h0, 0, 1'b0);
			chk_val(paused, 1'b0, "suspend while idle");
			wren();
			expect_op(k ? K_PROG : K_4K, k ? 24'h000310 : 24'h0, 0);
			if (k)
				q_mem.push_back(16'h1077);
			cmd(k ? OP_PP : OP_SE, k ? 64'h00031077 : 64'h0, k ? 32 : 24, 1'b0);
			cmd(OP_SUSP, 64'h0, 0, 1'b0);
			chk_val({paused, op_pause}, 2'b11, "paused at once");
			cyc(C);
			chk_val(busy, 1'b0, "busy after pause latency");
			nsrw = 0;
			nclr = 0;
			skip = 1'b1;
			wren();
			cmd(OP_WRSR1, 64'h0, 8, 1'b0);
			wren();
			cmd(OP_WRSR2, 64'h0, 8, 1'b0);
			chk_val(nsrw, 0, "status write while paused");
			wren();
			cmd(OP_SE, 64'h0, 24, 1'b0);
			wren();
			cmd(OP_QPP, 64'h00031055, 32, 1'b1);
			chk_val(nclr, 0, "page clear while paused");
			idle();
			skip = 1'b0;
			cmd(OP_RESM, 64'h0, 0, 1'b0);
			chk_val(paused, 1'b0, "resume clears pause");
			cyc(8);
			chk_val(busy, 1'b1, "busy after resume");
			cyc(C);
			idle();
		end
		done("suspend and resume");
		wren();
		expect_op(K_ALL, 24'h0, C * 40);
		cmd(OP_CE2, 64'h0, 0, 1'b0);
		cmd(OP_SUSP, 64'h0, 0, 1'b0);
		chk_val(paused, 1'b0, "suspend in array erase");
		cmd(OP_WREN, 64'h0, 0, 1'b0);
		cmd(OP_SE, 64'h0, 24, 1'b0);
		cmd(OP_RDSR1, 64'h0, 8, 1'b0);
		chk_val(host.rx, 8'h01, "status one while busy");
		cmd(OP_RDSR2, 64'h0, 8, 1'b0);
		chk_val(host.rx, 8'h02, "status two while busy");
		idle();
		done("array erase busy");
		wren();
		expect_op(K_4K, 24'h0, 0);
		cmd(OP_SE, 64'h0, 24, 1'b0);
		cmd(OP_SUSP, 64'h0, 0, 1'b0);
		cyc(C);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(6);
		chk_val({paused, busy, wlf}, 3'b000, "state after reset");
		cmd(OP_RESM, 64'h0, 0, 1'b0);
		chk_val({paused, busy}, 2'b00, "nothing pending after reset");
		done("reset in pause");
		final_report();
	end
endmodule : fpes_ctrl_tb
